// ==== rtl/lhr_limp_home_ctrl.sv ====
// limp-home clock supervision and stop recovery with apb registers
`timescale 1ns/1ps
module lhr_limp_home_ctrl
   import lhr_pkg::*;
#(
   parameter int CNT_W = lhr_pkg::CNT_W_DEF
) (
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // apb slave
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   output logic                  pready,
   output logic [31:0]           prdata,
   output logic                  pslverr,
   // supply, mode and clock sources
   input  wire logic             pll_supply,
   input  wire logic             normal_mode,
   input  wire logic             ext_reset,
   input  wire logic             clock_monitor_ok,
   input  wire logic             ext_clk_tick,
   input  wire logic             vco_tick,
   // cpu stop and wake-up
   input  wire logic             stop_exec,
   input  wire lhr_pkg::lhr_wake_s wake_src,
   // clock selects and status
   output logic                  internal_reset,
   output logic                  halted,
   output logic                  osc_enable,
   output logic                  fallback_active,
   output logic                  bus_clk_pll_select,
   output logic                  module_clk_select,
   output logic                  pll_power_on,
   output logic                  pll_clocks_modules,
   output logic                  clock_monitor_active,
   output logic                  cm_reset,
   output logic                  fallback_irq
);
   import lhr_pkg::*;

   if (CNT_W < 4 || CNT_W > 24)
   begin : g_bad_cnt_w
      $error("CNT_W out of range");
   end

   lhr_state_e         state_ff, nxt_state;
   lhr_ctrl_s          ctrl_ff;
   logic [SLOW_W-1:0]  slow_ff, slow_cnt_ff;
   logic               limp_ff, nxt_limp;
   logic               fallback_active_flag_ff, chg_ff;
   logic               pready_ff, pslverr_ff;
   logic [31:0]        prdata_ff;
   logic               set_change, cnt_clear, cm_rst_req, restart, por_pend_ff;
   logic               half_hit, xtick, src_tick, lh_allowed, cme_sw, wake;
   logic               wr_fire, rd_take;
   logic               internal_reset_ff, halted_ff, osc_enable_ff, fallback_active_ff;
   logic               bus_clk_pll_select_ff, mcs_ff, pll_on_ff, pll_mod_ff, cm_act_ff, cm_reset_ff, irq_ff;

   function automatic logic [31:0] rd_word(input logic [7:0] a);
      case (a)
         OFF_CTRL: rd_word = {{(32-CTRL_W){1'b0}}, ctrl_ff};
         OFF_STAT: rd_word = {28'h0000000, halted_ff, internal_reset_ff, chg_ff, fallback_active_flag_ff};
         OFF_SLOW: rd_word = {{(32-SLOW_W){1'b0}}, slow_ff};
         default:  rd_word = 32'h00000000;
      endcase
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == OFF_CTRL) || (a == OFF_STAT) || (a == OFF_SLOW);
   endfunction

   // fallback needs the pll supply and the software enable
   assign lh_allowed = pll_supply && !ctrl_ff.disable_fallback_mode;
   assign cme_sw     = ctrl_ff.clock_monitor_enable || ctrl_ff.forced_clock_monitor_enable;
   assign wake       = |wake_src;
   assign restart    = cm_rst_req || ext_reset || por_pend_ff;

   // apb: one wait state so every answer comes from a register
   assign wr_fire = psel && penable && pready_ff && pwrite;
   assign rd_take = psel && penable && !pready_ff;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_ff  <= 1'b0;
         prdata_ff  <= 32'h00000000;
         pslverr_ff <= 1'b0;
      end
      else
      begin
         pready_ff  <= rd_take;
         prdata_ff  <= (rd_take && !pwrite) ? rd_word(paddr) : 32'h00000000;
         pslverr_ff <= rd_take && !mapped(paddr);
      end
   end

   // control bits; any reset restores them
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_ff <= CTRL_RST;
         slow_ff <= '0;
      end
      else if (restart)
      begin
         ctrl_ff <= CTRL_RST;
         slow_ff <= '0;
      end
      else if (wr_fire && paddr == OFF_CTRL)
         ctrl_ff <= pwdata[CTRL_W-1:0];
      else if (wr_fire && paddr == OFF_SLOW)
         slow_ff <= pwdata[SLOW_W-1:0];
   end

   // slow divider; without fallback the source is the external clock only
   assign src_tick = (limp_ff && pll_supply) ? vco_tick : ext_clk_tick;
   assign xtick    = src_tick && (slow_cnt_ff == slow_ff) && (state_ff != ST_STOP);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         slow_cnt_ff <= '0;
      else if (state_ff == ST_STOP || xtick)
         slow_cnt_ff <= '0;
      else if (src_tick)
         slow_cnt_ff <= slow_cnt_ff + 1'b1;
   end

   lhr_stage_counter #(
      .CNT_W    (CNT_W)
   ) u_counter (
      .pclk     (pclk),
      .presetn  (presetn),
      .tick     (xtick),
      .clear    (cnt_clear),
      .half_hit (half_hit)
   );

   always_comb
   begin
      nxt_state  = state_ff;
      nxt_limp   = limp_ff;
      set_change = 1'b0;
      cnt_clear  = 1'b0;
      cm_rst_req = 1'b0;
      case (state_ff)
         ST_RESET:
         begin
            if (clock_monitor_ok)
               nxt_limp = 1'b0;
            if (half_hit)
            begin
               nxt_state  = ST_RUN;
               cnt_clear  = 1'b1;
               set_change = nxt_limp;
            end
         end
         ST_RUN:
         begin
            if (stop_exec)
            begin
               if (!lh_allowed && cme_sw)
                  cm_rst_req = 1'b1;
               else
                  nxt_state = ST_STOP;
            end
            else if (limp_ff)
            begin
               if (half_hit && clock_monitor_ok)
               begin
                  nxt_limp   = 1'b0;
                  set_change = 1'b1;
               end
            end
            else if (cme_sw && !clock_monitor_ok)
            begin
               if (lh_allowed)
               begin
                  nxt_limp   = 1'b1;
                  set_change = 1'b1;
                  cnt_clear  = 1'b1;
               end
               else
                  cm_rst_req = 1'b1;
            end
         end
         ST_STOP:
         begin
            if (wake)
            begin
               cnt_clear = 1'b1;
               if (!lh_allowed)
                  nxt_state = ctrl_ff.stop_exit_delay_enable ? ST_WAIT : ST_RUN;
               else if (ctrl_ff.stop_exit_delay_enable)
               begin
                  nxt_limp  = 1'b1;
                  nxt_state = ST_WAIT;
               end
               else if (clock_monitor_ok)
               begin
                  nxt_state  = ST_RUN;
                  nxt_limp   = 1'b0;
                  set_change = limp_ff;
               end
               else
               begin
                  nxt_limp   = 1'b1;
                  set_change = 1'b1;
                  nxt_state  = ST_RUN;
               end
            end
         end
         ST_WAIT:
         begin
            if (half_hit)
            begin
               cnt_clear = 1'b1;
               nxt_state = ST_RUN;
               if (limp_ff && clock_monitor_ok)
                  nxt_limp = 1'b0;
               else if (limp_ff)
                  set_change = 1'b1;
            end
         end
         default:
            nxt_state = ST_RESET;
      endcase
      if (restart)
      begin
         nxt_state  = ST_RESET;
         nxt_limp   = pll_supply && normal_mode;
         set_change = 1'b0;
         cnt_clear  = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_ff <= ST_RESET;
         limp_ff  <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         limp_ff  <= nxt_limp;
      end
   end

   // power-on: supply and mode are sampled on the first clocked cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         por_pend_ff <= 1'b1;
      else
         por_pend_ff <= 1'b0;
   end

   // status flag follows fallback changes; change flag is sticky, set beats clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fallback_active_flag_ff <= 1'b0;
         chg_ff   <= 1'b0;
      end
      else if (restart)
      begin
         fallback_active_flag_ff <= 1'b0;
         chg_ff   <= 1'b0;
      end
      else
      begin
         if (set_change)
            fallback_active_flag_ff <= nxt_limp;
         if (set_change)
            chg_ff <= 1'b1;
         else if (wr_fire && paddr == OFF_STAT && pwdata[STAT_CHANGE])
            chg_ff <= 1'b0;
      end
   end

   // outputs: all registered, so they trail the state by one cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         internal_reset_ff  <= 1'b1;
         halted_ff          <= 1'b0;
         osc_enable_ff      <= 1'b1;
         fallback_active_ff <= 1'b0;
         bus_clk_pll_select_ff            <= 1'b0;
         mcs_ff             <= 1'b0;
         pll_on_ff          <= 1'b0;
         pll_mod_ff         <= 1'b0;
         cm_act_ff          <= 1'b0;
         cm_reset_ff        <= 1'b0;
         irq_ff             <= 1'b0;
      end
      else
      begin
         internal_reset_ff  <= (state_ff == ST_RESET);
         halted_ff          <= (state_ff == ST_STOP) || (state_ff == ST_WAIT);
         osc_enable_ff      <= (state_ff != ST_STOP) || ctrl_ff.pseudo_halt_enable;
         fallback_active_ff <= limp_ff;
         // software copies stay untouched in fallback, so exit restores them
         bus_clk_pll_select_ff            <= limp_ff || ctrl_ff.bus_clk_pll_select;
         mcs_ff             <= !limp_ff && ctrl_ff.module_clk_select;
         pll_on_ff          <= pll_supply && (limp_ff || ctrl_ff.pll_power_on);
         pll_mod_ff         <= limp_ff;
         cm_act_ff          <= limp_ff || (cme_sw && !(state_ff == ST_STOP && lh_allowed));
         cm_reset_ff        <= cm_rst_req;
         irq_ff             <= chg_ff && ctrl_ff.fallback_irq_enable;
      end
   end

   assign pready               = pready_ff;
   assign prdata               = prdata_ff;
   assign pslverr              = pslverr_ff;
   assign internal_reset       = internal_reset_ff;
   assign halted               = halted_ff;
   assign osc_enable           = osc_enable_ff;
   assign fallback_active      = fallback_active_ff;
   assign bus_clk_pll_select   = bus_clk_pll_select_ff;
   assign module_clk_select    = mcs_ff;
   assign pll_power_on         = pll_on_ff;
   assign pll_clocks_modules   = pll_mod_ff;
   assign clock_monitor_active = cm_act_ff;
   assign cm_reset             = cm_reset_ff;
   assign fallback_irq         = irq_ff;

   AST_FORCED_SELECTS: assert property (@(posedge pclk) disable iff (!presetn)
      limp_ff |=> bus_clk_pll_select_ff && !mcs_ff && pll_mod_ff)
      else $error("fallback clock selects not forced");

   AST_RESET_PERIOD: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(internal_reset_ff) |-> $past(half_hit, 2))
      else $error("internal reset released without half count");

   AST_RELEASE_FALLBACK: assert property (@(posedge pclk) disable iff (!presetn)
      (state_ff == ST_RESET && half_hit && nxt_limp && !restart) |=> fallback_active_flag_ff && chg_ff ##1 internal_reset_ff == 1'b0)
      else $error("fallback release flags wrong");

   AST_CLOCK_RETURN: assert property (@(posedge pclk) disable iff (!presetn)
      (state_ff == ST_RUN && limp_ff && half_hit && clock_monitor_ok && !stop_exec && !restart)
      |=> !limp_ff && !fallback_active_flag_ff && chg_ff)
      else $error("clock return not handled");

   AST_STOP_MON_RESET: assert property (@(posedge pclk) disable iff (!presetn)
      (state_ff == ST_RUN && stop_exec && !lh_allowed && cme_sw) |=> cm_reset_ff && state_ff == ST_RESET)
      else $error("stop with monitor did not reset");

   AST_STOP_MASK: assert property (@(posedge pclk) disable iff (!presetn)
      (state_ff == ST_STOP && lh_allowed && !limp_ff) |=> !cm_act_ff)
      else $error("monitor not masked in stop");

   AST_FAST_CLEAN: assert property (@(posedge pclk) disable iff (!presetn)
      (state_ff == ST_STOP && wake && lh_allowed && !ctrl_ff.stop_exit_delay_enable && clock_monitor_ok
       && !restart) |=> state_ff == ST_RUN && !limp_ff ##1 !halted_ff && !fallback_active_flag_ff)
      else $error("fast recovery entered fallback");

   AST_IRQ_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      (chg_ff && ctrl_ff.fallback_irq_enable) |=> irq_ff)
      else $error("interrupt request missing");

   AST_NO_SUPPLY: assert property (@(posedge pclk) disable iff (!presetn)
      (!pll_supply && !limp_ff) |=> !limp_ff)
      else $error("fallback without pll supply");

   AST_DELAY_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
      (state_ff == ST_STOP && wake && ctrl_ff.stop_exit_delay_enable && !restart) |=> state_ff == ST_WAIT ##1 halted_ff)
      else $error("delay wait skipped");
endmodule // lhr_limp_home_ctrl

// ==== rtl/lhr_pkg.sv ====
// constants and types for the limp-home and stop recovery block
// Overview of operation
// - reset sets monitor, pll power; clears disable
// - powering up without external clock enters fallback
// - fallback forces pll select, module clocks from pll
// - first counter half-count defines internal reset
// - clock seen during reset: leave fallback, release
// - no clock at release: fallback, set both flags
// - fallback polls monitor after 4096, then 8192
// - clock found: leave fallback, interrupt if enabled
// - no pll supply: no fallback, external clock only
// - delay bit adds half-count wait on stop exit
// - delay counter runs from slow divider output
// - reset, interrupt pins, key, can wake end stop
// - no fallback, monitor off: stop, external resume, delayed only with delay bit
// - no fallback, monitor on: stop causes monitor reset
// - fallback allowed: monitor masked in stop, forced after
// - delayed fallback exit checks monitor after wait
// - clock return clears status, sets change flag
// - no delay, no clock: run in fallback immediately
// - leaving fallback restores previous clock selects
// - good clock, no delay: no fallback, instant exit
// - pseudo halt keeps oscillator running, same wakes
package lhr_pkg;
   localparam logic [7:0] OFF_CTRL  = 8'h00;
   localparam logic [7:0] OFF_STAT  = 8'h04;
   localparam logic [7:0] OFF_SLOW  = 8'h08;
   localparam int         SLOW_W    = 6;
   localparam int         CNT_W_DEF = 13;

   typedef struct packed {
      logic auto_bw;
      logic fallback_irq_enable;
      logic pseudo_halt_enable;
      logic stop_exit_delay_enable;
      logic module_clk_select;
      logic bus_clk_pll_select;
      logic disable_fallback_mode;
      logic pll_power_on;
      logic forced_clock_monitor_enable;
      logic clock_monitor_enable;
   } lhr_ctrl_s;

   localparam int         CTRL_W   = $bits(lhr_ctrl_s);
   localparam lhr_ctrl_s  CTRL_RST = '{pll_power_on: 1'b1, clock_monitor_enable: 1'b1, default: 1'b0};

   localparam int STAT_ACTIVE = 0;
   localparam int STAT_CHANGE = 1;
   localparam int STAT_RESET  = 2;
   localparam int STAT_HALT   = 3;

   typedef struct packed {
      logic ext_irq_edge;
      logic nonmaskable_interrupt_pin;
      logic key_wake_j;
      logic key_wake_h;
      logic can_wake;
   } lhr_wake_s;

   typedef enum logic [1:0] {ST_RESET, ST_RUN, ST_STOP, ST_WAIT} lhr_state_e;
endpackage

// ==== rtl/lhr_stage_counter.sv ====
// free-running stage counter with half-count strobe
`timescale 1ns/1ps
module lhr_stage_counter #(
   parameter int CNT_W = 13
) (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // control
   input  wire logic tick,
   input  wire logic clear,
   // status
   output logic      half_hit
);
   localparam logic [CNT_W-1:0] HALF_M1 = {1'b0, {(CNT_W-1){1'b1}}};
   logic [CNT_W-1:0] count_ff;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count_ff <= '0;
      else if (clear)
         count_ff <= '0;
      else if (tick)
         count_ff <= count_ff + 1'b1;
   end

   // strobe when the count reaches half span; wraps so it recurs every full span
   // clear stays out of the strobe: the controller derives clear from it, a loop otherwise
   assign half_hit = tick && (count_ff == HALF_M1);
endmodule // lhr_stage_counter

// ==== verif/lhr_osc_model.sv ====
// external clock source and minimum-frequency vco tick model
`timescale 1ns/1ps
module lhr_osc_model #(
   parameter int EXT_P = 2,
   parameter int VCO_P = 3
) (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // source control
   input  wire logic present,
   // ticks and monitor
   output logic      ext_clk_tick,
   output logic      vco_tick,
   output logic      clock_monitor_ok
);
   int ext_cnt_ff;
   int vco_cnt_ff;

   // a missing source gives no external ticks; vco ticks go on, so the counter can run in fallback
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ext_cnt_ff       <= 0;
         vco_cnt_ff       <= 0;
         ext_clk_tick     <= 1'b0;
         vco_tick         <= 1'b0;
         clock_monitor_ok <= 1'b0;
      end
      else
      begin
         ext_cnt_ff       <= (ext_cnt_ff == EXT_P - 1) ? 0 : ext_cnt_ff + 1;
         vco_cnt_ff       <= (vco_cnt_ff == VCO_P - 1) ? 0 : vco_cnt_ff + 1;
         ext_clk_tick     <= present && (ext_cnt_ff == 0);
         vco_tick         <= (vco_cnt_ff == 0);
         clock_monitor_ok <= present;
      end
   end
endmodule // lhr_osc_model

// ==== verif/lhr_limp_home_ctrl_test.sv ====
// self-checking bench for the limp-home and stop recovery block
`timescale 1ns/1ps
module lhr_limp_home_ctrl_test;
   import lhr_pkg::*;
   localparam int CW   = 5;
   localparam int HALF = 2 ** (CW - 1);
   localparam int EP   = 2;
   localparam int VP   = 3;
   localparam lhr_wake_s WK = lhr_wake_s'(5'h01);
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pll_supply, normal_mode, ext_reset, present, stop_exec;
   logic        clock_monitor_ok, ext_clk_tick, vco_tick, internal_reset, halted;
   logic        osc_enable, fallback_active, bus_clk_pll_select, module_clk_select;
   logic        pll_power_on, pll_clocks_modules, clock_monitor_active, cm_reset, fallback_irq;
   lhr_wake_s   wake_src;
   int          n_fail, checks_done;

   lhr_osc_model #(.EXT_P(EP), .VCO_P(VP)) i_lhr_osc_model (.pclk(pclk), .presetn(presetn),
      .present(present), .ext_clk_tick(ext_clk_tick), .vco_tick(vco_tick),
      .clock_monitor_ok(clock_monitor_ok));

   lhr_limp_home_ctrl #(.CNT_W(CW)) i_lhr_limp_home_ctrl (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .pll_supply(pll_supply),
      .normal_mode(normal_mode), .ext_reset(ext_reset), .clock_monitor_ok(clock_monitor_ok),
      .ext_clk_tick(ext_clk_tick), .vco_tick(vco_tick), .stop_exec(stop_exec),
      .wake_src(wake_src), .internal_reset(internal_reset), .halted(halted),
      .osc_enable(osc_enable), .fallback_active(fallback_active),
      .bus_clk_pll_select(bus_clk_pll_select), .module_clk_select(module_clk_select),
      .pll_power_on(pll_power_on), .pll_clocks_modules(pll_clocks_modules),
      .clock_monitor_active(clock_monitor_active), .cm_reset(cm_reset),
      .fallback_irq(fallback_irq));

   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   function automatic logic sig(input int k);
      case (k)
         0: return internal_reset;
         1: return fallback_active;
         2: return halted;
         default: return cm_reset;
      endcase
   endfunction

   // bounded wait on a design output, n returns the cycles spent
   task automatic wait_for(input int k, input logic v, input int lim, output int n);
      n = 0;
      while (sig(k) !== v)
      begin
         if (n >= lim)
         begin
            n_fail++;
            $display("mismatch at %0t: wait %0d timed out", $time, k);
            print_verdict();
         end
         @(posedge pclk);
         n++;
      end
   endtask

   // apb master: holds the request until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 64);
      if (n >= 64)
      begin
         n_fail++;
         $display("mismatch at %0t: apb timed out", $time);
         print_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
      apb(1'b0, a, 32'h0);
      check(rd, exp, msg);
   endtask

   task automatic stop_run(input logic [31:0] ctrl, input lhr_wake_s w, input int lo, input int hi,
                           input logic keep);
      int n;
      apb(1'b1, OFF_CTRL, ctrl);
      @(posedge pclk);
      stop_exec <= 1'b1;
      @(posedge pclk);
      stop_exec <= 1'b0;
      wait_for(2, 1'b1, 8, n);
      present <= keep;
      repeat (4) @(posedge pclk);
      check(osc_enable, ctrl[7], "oscillator in stop");
      wake_src <= w;
      @(posedge pclk);
      wake_src <= '0;
      wait_for(2, 1'b0, 600, n);
      check(n >= lo && n <= hi, 1'b1, "stop exit latency");
   endtask

   task automatic t_static();
      repeat (100) @(posedge pclk);
      check(internal_reset, 1'b1, "static without supply");
      check(pll_power_on, 1'b0, "pll off without supply");
      rd_chk(OFF_CTRL, 32'h5, "ctrl reset value");
      apb(1'b0, 8'h0c, 32'h0);
      check(err, 1'b1, "unmapped read error");
      check(rd, 32'h0, "unmapped read data");
      $display("static test done");
   endtask

   task automatic t_powerup();
      int n;
      pll_supply <= 1'b1;
      ext_reset  <= 1'b1;
      @(posedge pclk);
      ext_reset  <= 1'b0;
      repeat (3) @(posedge pclk);
      check(fallback_active, 1'b1, "powerup fallback");
      check({bus_clk_pll_select, module_clk_select, pll_clocks_modules}, 3'b101, "forced clocks");
      check(pll_power_on, 1'b1, "pll powered");
      wait_for(0, 1'b0, 400, n);
      check(n >= HALF * VP - 2 * VP - 4 && n <= HALF * VP + 2 * VP, 1'b1, "reset period");
      repeat (2) @(posedge pclk);
      rd_chk(OFF_STAT, 32'h3, "flags after release");
      check(fallback_irq, 1'b0, "masked change flag");
      apb(1'b1, OFF_CTRL, 32'h125);
      present <= 1'b1;
      repeat (20) @(posedge pclk);
      check(fallback_active, 1'b1, "no early poll");
      wait_for(1, 1'b0, 60, n);
      repeat (2) @(posedge pclk);
      check(fallback_irq, 1'b1, "change flag requests");
      check({bus_clk_pll_select, module_clk_select}, 2'b01, "selects restored");
      rd_chk(OFF_STAT, 32'h2, "flags after return");
      check(fallback_irq, 1'b1, "change flag sticky");
      apb(1'b1, OFF_STAT, 32'h2);
      repeat (2) @(posedge pclk);
      check(fallback_irq, 1'b0, "change flag cleared");
      $display("powerup test done");
   endtask

   task automatic t_stops();
      int i;
      int n;
      int d;
      d = HALF * EP;
      for (i = 0; i < 5; i++)
         stop_run(i[0] ? 32'h088 : 32'h008, lhr_wake_s'(5'h01 << i), 0, 4, 1'b1);
      stop_run(32'h048, WK, d - EP, d + EP + 6, 1'b1);
      apb(1'b1, OFF_SLOW, 32'h1);
      stop_run(32'h048, WK, 2 * d - EP, 2 * d + EP + 6, 1'b1);
      apb(1'b1, OFF_SLOW, 32'h0);
      stop_run(32'h001, WK, 0, 4, 1'b1);
      check(fallback_active, 1'b0, "no fallback on fast exit");
      rd_chk(OFF_CTRL, 32'h1, "no monitor reset in stop");
      stop_run(32'h041, WK, HALF * VP - VP, HALF * VP + VP + 6, 1'b1);
      check(fallback_active, 1'b0, "delayed normal exit");
      rd_chk(OFF_STAT, 32'h0, "no flags on normal exit");
      stop_run(32'h000, WK, 0, 4, 1'b0);
      repeat (2) @(posedge pclk);
      check(fallback_active, 1'b1, "fast exit into fallback");
      check(clock_monitor_active, 1'b1, "monitor forced");
      present <= 1'b1;
      wait_for(1, 1'b0, 200, n);
      check(n <= 2 * HALF * VP + 10, 1'b1, "poll finds clock");
      $display("stop test done");
   endtask

   task automatic t_monitor_reset();
      int n;
      apb(1'b1, OFF_CTRL, 32'h009);
      @(posedge pclk);
      stop_exec <= 1'b1;
      @(posedge pclk);
      stop_exec <= 1'b0;
      wait_for(3, 1'b1, 10, n);
      check(n <= 6, 1'b1, "stop gives monitor reset");
      wait_for(0, 1'b1, 10, n);
      wait_for(0, 1'b0, 400, n);
      repeat (2) @(posedge pclk);
      check(fallback_active, 1'b0, "clock seen in reset");
      rd_chk(OFF_CTRL, 32'h5, "ctrl after monitor reset");
      $display("monitor reset test done");
   endtask

   initial
   begin
      n_fail = 0;
      checks_done = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pll_supply = 1'b0;
      normal_mode = 1'b1;
      ext_reset = 1'b0;
      present = 1'b0;
      stop_exec = 1'b0;
      wake_src = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_static();
      t_powerup();
      t_stops();
      t_monitor_reset();
      print_verdict();
   end
endmodule // lhr_limp_home_ctrl_test
